// *** logic/edf_pkg.sv ***
package edf_pkg;

  // ----------------------------------------------------------------
  // descriptor geometry
  // ----------------------------------------------------------------
  localparam logic [5:0] EDF_LEN_SHORT = 6'd16;
  localparam logic [5:0] EDF_LEN_LONG = 6'd52;
  localparam logic [5:0] EDF_TAG_FIRST = 6'd12;
  localparam logic [5:0] EDF_TAG_LAST = 6'd47;
  localparam int EDF_TAG_BYTES = 36;
  localparam logic [5:0] EDF_BYTE_ADDR_HI = 6'd0;
  localparam logic [5:0] EDF_BYTE_ADDR_LO = 6'd1;
  localparam logic [5:0] EDF_BYTE_FLAGS = 6'd2;
  localparam logic [5:0] EDF_BYTE_ASC = 6'd4;
  localparam logic [5:0] EDF_BYTE_ASCQ = 6'd5;
  localparam logic [5:0] EDF_BYTE_SVALID = 6'd9;
  localparam logic [5:0] EDF_BYTE_SRC_HI = 6'd10;
  localparam logic [5:0] EDF_BYTE_SRC_LO = 6'd11;

  // ----------------------------------------------------------------
  // flag byte field positions; source-valid bit is bit 7 of byte 9
  // ----------------------------------------------------------------
  localparam int EDF_BIT_FULL = 0;
  localparam int EDF_BIT_OPERATOR = 1;
  localparam int EDF_BIT_EXCEPT = 2;
  localparam int EDF_BIT_ACCESS = 3;
  localparam int EDF_BIT_EXPORT = 4;
  localparam int EDF_BIT_IMPORT = 5;
  localparam int EDF_BIT_SVALID = 7;

  // ----------------------------------------------------------------
  // additional sense codes
  // ----------------------------------------------------------------
  localparam logic [7:0] EDF_ASC_NONE = 8'h00;
  localparam logic [7:0] EDF_ASC_NATIVE = 8'h83;
  localparam logic [7:0] EDF_ASC_EMU_A = 8'h90;
  localparam logic [7:0] EDF_Q_NONE = 8'h00;
  localparam logic [7:0] EDF_Q_LABEL_ERR = 8'h01;
  localparam logic [7:0] EDF_Q_MAG_ABSENT = 8'h02;
  localparam logic [7:0] EDF_Q_FULL_LABEL_Q = 8'h03;
  localparam logic [7:0] EDF_Q_FULL_Q = 8'h07;
  localparam logic [7:0] EDF_Q_NO_LABEL = 8'h09;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EDF_EMU_NATIVE = 2'b00,
    EDF_EMU_A = 2'b01,
    EDF_EMU_B = 2'b10
  } edf_emu_e;

  typedef enum logic [1:0] {
    EDF_EL_HANDLER = 2'b00,
    EDF_EL_STORAGE = 2'b01,
    EDF_EL_PORT = 2'b10,
    EDF_EL_DRIVE = 2'b11
  } edf_elem_e;

  typedef enum logic [1:0] {
    EDF_ST_IDLE = 2'b01,
    EDF_ST_EMIT = 2'b10
  } edf_state_e;

  // fifo word: last flag above the byte
  localparam int EDF_FIFO_W = 9;
  localparam int EDF_FIFO_D = 8;

endpackage

// *** logic/edf_fifo_if.sv ***
interface edf_fifo_if #(
  parameter int W = 9
);
  logic wrValid;
  logic wrReady;
  logic [W-1:0] wrData;
  logic rdValid;
  logic rdReady;
  logic [W-1:0] rdData;

  modport producer (output wrValid, output wrData, input wrReady);
  modport store (input wrValid, input wrData, output wrReady,
                 output rdValid, output rdData, input rdReady);
  modport consumer (input rdValid, input rdData, output rdReady);
endinterface

// *** logic/edf_byte_fifo.sv ***
module edf_byte_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // both sides
  edf_fifo_if.store fifo
);

  localparam int AW = $clog2(D);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (D < 2 || (1 << AW) != D || W < 1) begin : g_bad
    $error("edf_byte_fifo: depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem [D];
  logic [AW:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic doWr, doRd;

  // ------------------------------------------------------------
  // pointers, one extra bit tells full from empty
  // ------------------------------------------------------------
  assign fifo.wrReady = (wrPtr_q - rdPtr_q) != (AW+1)'(D);
  assign fifo.rdValid = wrPtr_q != rdPtr_q;
  assign fifo.rdData = mem[rdPtr_q[AW-1:0]];
  assign doWr = fifo.wrValid && fifo.wrReady;
  assign doRd = fifo.rdValid && fifo.rdReady;

  // next pointer values
  always_comb begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    if (doWr) begin
      wrPtr_d = wrPtr_q + 1'b1;
    end
    if (doRd) begin
      rdPtr_d = rdPtr_q + 1'b1;
    end
  end

  // pointer registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
  end

  // storage needs no reset; only words under the pointers are read
  always_ff @(posedge ref_clk) begin
    if (doWr) begin
      mem[wrPtr_q[AW-1:0]] <= fifo.wrData;
    end
  end

endmodule // edf_byte_fifo

// *** logic/edf_formatter.sv ***
// Overview of operation
// - first emulation: magazine absent gives 90/02, full questionable gives 90/03.
// - second emulation: missing or unreadable label gives 83/01.
// - second emulation: questionable full and label gives 83/03, barcode or not.
// - source-valid is 1 only when invert and source address are valid.
// - invert bit is always 0 in every descriptor.
// - with source-valid set, source address is last storage element taken from.
// - only storage qualifies as source unless options admit drive or port.
// - tag flag 1 adds 36-byte tag, 52 bytes; flag 0 gives 16 bytes.
// - one handler descriptor per report with fixed byte layout.
// - storage access bit 1 unless slot in sequential range or magazine missing.
// - storage count follows model and magazines; fixed slots are storage.
// - port byte 2 bits 5..0: import, export, access, exception, operator, full.
// - port access is 1 when retracted, 0 when not.
// - port access forced to 0 when front slot access is configured.
// - export-enable bit mirrors the export configuration.
// - import-enable bit mirrors the import configuration.
// - operator-placed bit is 1 for operator insertion, 0 for handler placement.
// - exception 1 when status uncertain, still giving last known full and tag.
// - full bit is 1 with a cartridge, 0 when empty.
module edf_formatter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // report framing
  input wire logic reportStart,
  input wire logic primary_tag_present,
  input wire edf_pkg::edf_emu_e emuMode,
  input wire logic barcodeFitted,
  // configuration
  input wire logic cfgSrcDrive,
  input wire logic cfgSrcPort,
  input wire logic cfgFrontAccess,
  input wire logic export_permit,
  input wire logic import_permit,
  // element request
  input wire logic reqValid,
  input wire edf_pkg::edf_elem_e reqType,
  input wire logic [15:0] reqAddr,
  input wire logic reqFull,
  input wire logic reqMagAbsent,
  input wire logic reqFullQuestion,
  input wire logic reqLabelQuestion,
  input wire logic reqLabelMissing,
  input wire logic reqSeqRange,
  input wire logic reqRetracted,
  input wire logic operator_placed,
  input wire logic reqSrcKnown,
  input wire edf_pkg::edf_elem_e reqSrcType,
  input wire logic [15:0] reqSrcAddr,
  input wire logic [8*edf_pkg::EDF_TAG_BYTES-1:0] reqTag,
  // element request answer
  output logic reqReady,
  output logic dupHandler,
  output logic [15:0] storageCount,
  // descriptor byte stream
  output logic outValid,
  output logic [7:0] outData,
  output logic outLast,
  input wire logic outReady
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // sense code pair {asc, ascq}; zero means no exception
  function automatic logic [15:0] senseCode(edf_pkg::edf_emu_e emu, logic magAbsent,
                                            logic fullQ, logic labelQ, logic labelMiss,
                                            logic barcode);
    logic [15:0] r;
    r = {edf_pkg::EDF_ASC_NONE, edf_pkg::EDF_Q_NONE};
    case (emu)
      edf_pkg::EDF_EMU_A: begin
        if (magAbsent) begin
          r = {edf_pkg::EDF_ASC_EMU_A, edf_pkg::EDF_Q_MAG_ABSENT};
        end else if (fullQ || labelQ) begin
          r = {edf_pkg::EDF_ASC_EMU_A, edf_pkg::EDF_Q_FULL_LABEL_Q};
        end
      end
      edf_pkg::EDF_EMU_B: begin
        // questionable state wins over a label fault: data may be stale anyway
        if (fullQ || labelQ) begin
          r = {edf_pkg::EDF_ASC_NATIVE, edf_pkg::EDF_Q_FULL_LABEL_Q};
        end else if (labelMiss) begin
          r = {edf_pkg::EDF_ASC_NATIVE, edf_pkg::EDF_Q_LABEL_ERR};
        end
      end
      default: begin
        if (magAbsent) begin
          r = {edf_pkg::EDF_ASC_NATIVE, edf_pkg::EDF_Q_MAG_ABSENT};
        end else if (fullQ || labelQ) begin
          r = {edf_pkg::EDF_ASC_NATIVE, barcode ? edf_pkg::EDF_Q_FULL_LABEL_Q : edf_pkg::EDF_Q_FULL_Q};
        end else if (labelMiss && barcode) begin
          r = {edf_pkg::EDF_ASC_NATIVE, edf_pkg::EDF_Q_NO_LABEL};
        end
      end
    endcase
    return r;
  endfunction

  // does an element of this type count as a source element
  function automatic logic srcQualifies(edf_pkg::edf_elem_e t, logic drv, logic prt);
    logic r;
    r = 1'b0;
    case (t)
      edf_pkg::EDF_EL_STORAGE: r = 1'b1;
      edf_pkg::EDF_EL_DRIVE: r = drv;
      edf_pkg::EDF_EL_PORT: r = prt;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------
  // latched descriptor fields
  // ------------------------------------------------------------
  edf_pkg::edf_state_e state_q, state_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] flags_q, flags_d;
  logic [15:0] sense_q, sense_d;
  logic svalid_q, svalid_d;
  logic [15:0] src_q, src_d;
  logic [8*edf_pkg::EDF_TAG_BYTES-1:0] tag_q, tag_d;
  logic [5:0] len_q, len_d;
  logic [5:0] idx_q, idx_d;
  logic handlerSent_q, handlerSent_d;
  logic dupHandler_q, dupHandler_d;
  logic [15:0] storageCount_q, storageCount_d;
  logic reqReady_q, reqReady_d;
  logic [15:0] senseNow;
  logic exceptNow, accessNow, svalidNow, take;
  logic [7:0] curByte;
  logic [5:0] tagOff;

  edf_fifo_if #(.W(edf_pkg::EDF_FIFO_W)) fq ();

  // fifo shields the serializer from a stalled initiator
  edf_byte_fifo #(.W(edf_pkg::EDF_FIFO_W), .D(edf_pkg::EDF_FIFO_D)) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .fifo(fq.store)
  );

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  assign take = reqValid && reqReady_q;
  assign senseNow = senseCode(emuMode, reqMagAbsent, reqFullQuestion, reqLabelQuestion,
                              reqLabelMissing, barcodeFitted);
  assign exceptNow = senseNow != {edf_pkg::EDF_ASC_NONE, edf_pkg::EDF_Q_NONE};
  assign svalidNow = reqSrcKnown && srcQualifies(reqSrcType, cfgSrcDrive, cfgSrcPort);
  // storage access depends on slot, port access on retraction and front mode
  assign accessNow = (reqType == edf_pkg::EDF_EL_PORT) ?
                     (reqRetracted && !cfgFrontAccess) :
                     (!reqSeqRange && !reqMagAbsent);

  // ------------------------------------------------------------
  // byte selection; everything not named reads zero
  // ------------------------------------------------------------
  assign tagOff = idx_q - edf_pkg::EDF_TAG_FIRST;
  always_comb begin
    curByte = 8'h00;
    if (idx_q == edf_pkg::EDF_BYTE_ADDR_HI) begin
      curByte = addr_q[15:8];
    end else if (idx_q == edf_pkg::EDF_BYTE_ADDR_LO) begin
      curByte = addr_q[7:0];
    end else if (idx_q == edf_pkg::EDF_BYTE_FLAGS) begin
      curByte = flags_q;
    end else if (idx_q == edf_pkg::EDF_BYTE_ASC) begin
      curByte = sense_q[15:8];
    end else if (idx_q == edf_pkg::EDF_BYTE_ASCQ) begin
      curByte = sense_q[7:0];
    end else if (idx_q == edf_pkg::EDF_BYTE_SVALID) begin
      curByte = {svalid_q, 7'h00}; // invert stays 0
    end else if (idx_q == edf_pkg::EDF_BYTE_SRC_HI) begin
      curByte = svalid_q ? src_q[15:8] : 8'h00;
    end else if (idx_q == edf_pkg::EDF_BYTE_SRC_LO) begin
      curByte = svalid_q ? src_q[7:0] : 8'h00;
    end else if (len_q == edf_pkg::EDF_LEN_LONG && idx_q >= edf_pkg::EDF_TAG_FIRST &&
                 idx_q <= edf_pkg::EDF_TAG_LAST) begin
      // tag byte 0 is the top of the bus
      curByte = tag_q[8*(edf_pkg::EDF_TAG_BYTES-1-int'(tagOff)) +: 8];
    end
  end

  assign fq.wrValid = (state_q == edf_pkg::EDF_ST_EMIT);
  assign fq.wrData = {idx_q == len_q - 6'd1, curByte};

  // ------------------------------------------------------------
  // descriptor sequencer, next state
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    flags_d = flags_q;
    sense_d = sense_q;
    svalid_d = svalid_q;
    src_d = src_q;
    tag_d = tag_q;
    len_d = len_q;
    idx_d = idx_q;
    handlerSent_d = handlerSent_q;
    dupHandler_d = 1'b0;
    storageCount_d = storageCount_q;
    reqReady_d = reqReady_q;
    case (state_q)
      edf_pkg::EDF_ST_IDLE: begin
        if (reportStart) begin
          handlerSent_d = 1'b0;
          storageCount_d = 16'h0000;
        end
        if (take && reqType == edf_pkg::EDF_EL_HANDLER && handlerSent_q && !reportStart) begin
          dupHandler_d = 1'b1; // a second handler is dropped
        end else if (take) begin
          addr_d = reqAddr;
          sense_d = senseNow;
          svalid_d = svalidNow;
          src_d = reqSrcAddr;
          // tag carries the last known label even under an exception
          tag_d = reqTag;
          len_d = primary_tag_present ? edf_pkg::EDF_LEN_LONG : edf_pkg::EDF_LEN_SHORT;
          idx_d = 6'd0;
          flags_d = 8'h00;
          flags_d[edf_pkg::EDF_BIT_FULL] = reqFull;
          flags_d[edf_pkg::EDF_BIT_EXCEPT] = exceptNow;
          case (reqType)
            edf_pkg::EDF_EL_HANDLER: begin
              handlerSent_d = 1'b1;
            end
            edf_pkg::EDF_EL_STORAGE: begin
              flags_d[edf_pkg::EDF_BIT_ACCESS] = accessNow;
              storageCount_d = storageCount_d + 16'h0001; // from cleared value on start
            end
            edf_pkg::EDF_EL_PORT: begin
              flags_d[edf_pkg::EDF_BIT_ACCESS] = accessNow;
              flags_d[edf_pkg::EDF_BIT_OPERATOR] = operator_placed;
              flags_d[edf_pkg::EDF_BIT_EXPORT] = export_permit;
              flags_d[edf_pkg::EDF_BIT_IMPORT] = import_permit;
            end
            default: begin
              flags_d = flags_d; // drive slots get the common fields only
            end
          endcase
          reqReady_d = 1'b0;
          state_d = edf_pkg::EDF_ST_EMIT;
        end
      end
      edf_pkg::EDF_ST_EMIT: begin
        // stalls while the fifo is full, which holds the requester off
        if (fq.wrReady) begin
          if (idx_q == len_q - 6'd1) begin
            reqReady_d = 1'b1;
            state_d = edf_pkg::EDF_ST_IDLE;
          end else begin
            idx_d = idx_q + 6'd1; // ascending byte order
          end
        end
      end
      default: begin
        reqReady_d = 1'b1;
        state_d = edf_pkg::EDF_ST_IDLE;
      end
    endcase
  end

  // descriptor sequencer registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_q <= edf_pkg::EDF_ST_IDLE;
      addr_q <= 16'h0000;
      flags_q <= 8'h00;
      sense_q <= 16'h0000;
      svalid_q <= 1'b0;
      src_q <= 16'h0000;
      tag_q <= '0;
      len_q <= edf_pkg::EDF_LEN_SHORT;
      idx_q <= 6'd0;
      handlerSent_q <= 1'b0;
      dupHandler_q <= 1'b0;
      storageCount_q <= 16'h0000;
      reqReady_q <= 1'b1;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      flags_q <= flags_d;
      sense_q <= sense_d;
      svalid_q <= svalid_d;
      src_q <= src_d;
      tag_q <= tag_d;
      len_q <= len_d;
      idx_q <= idx_d;
      handlerSent_q <= handlerSent_d;
      dupHandler_q <= dupHandler_d;
      storageCount_q <= storageCount_d;
      reqReady_q <= reqReady_d;
    end
  end

  // ------------------------------------------------------------
  // output stage so the stream leaves straight from flops
  // ------------------------------------------------------------
  logic outValid_q, outValid_d;
  logic [edf_pkg::EDF_FIFO_W-1:0] outWord_q, outWord_d;

  assign fq.rdReady = !outValid_q || outReady;

  // next output word
  always_comb begin
    outValid_d = outValid_q;
    outWord_d = outWord_q;
    if (fq.rdReady) begin
      outValid_d = fq.rdValid;
      if (fq.rdValid) begin
        outWord_d = fq.rdData;
      end
    end
  end

  // output registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      outValid_q <= 1'b0;
      outWord_q <= '0;
    end else begin
      outValid_q <= outValid_d;
      outWord_q <= outWord_d;
    end
  end

  assign outValid = outValid_q;
  assign outData = outWord_q[7:0];
  assign outLast = outWord_q[8];
  assign reqReady = reqReady_q;
  assign dupHandler = dupHandler_q;
  assign storageCount = storageCount_q;

endmodule // edf_formatter

// *** test/edf_formatter_properties.sv ***
module edf_formatter_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // request side
  input wire logic reqValid,
  input wire edf_pkg::edf_elem_e reqType,
  input wire logic reqReady,
  input wire logic dupHandler,
  input wire logic [15:0] storageCount,
  // descriptor stream
  input wire logic outValid,
  input wire logic [7:0] outData,
  input wire logic outLast,
  input wire logic outReady
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // byte position tracking
  // ----------------------------------------------------------------
  logic [5:0] byteIdx_q;
  logic [5:0] byteIdx_d;
  logic take;
  assign take = outValid && outReady;

  // position of the byte now offered, back to zero after each end marker
  always_comb begin
    byteIdx_d = byteIdx_q;
    if (take) begin
      byteIdx_d = outLast ? 6'h00 : byteIdx_q + 6'h01;
    end
  end

  // registered position, cleared by reset
  always_ff @(posedge ref_clk) begin
    byteIdx_q <= rst_b ? byteIdx_d : 6'h00;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_hold_stall: assert property (outValid && !outReady |=> outValid && $stable(outData) && $stable(outLast))
    else $error("stream byte changed while stalled");
  a_len_match: assert property (take && outLast |-> byteIdx_q == 6'h0f || byteIdx_q == 6'h33)
    else $error("descriptor length not 16 or 52");
  a_len_bound: assert property (take |-> byteIdx_q <= 6'h33)
    else $error("descriptor runs past 52 bytes");
  a_pad_zero: assert property (take && byteIdx_q >= 6'h30 |-> outData == 8'h00)
    else $error("trailing pad byte not zero");
  a_byte3_zero: assert property (take && byteIdx_q == 6'h03 |-> outData == 8'h00)
    else $error("reserved byte 3 not zero");
  a_invert_zero: assert property (take && byteIdx_q == 6'h09 |-> outData[6:0] == 7'h00)
    else $error("invert or reserved bits of byte 9 set");
  a_flag_top: assert property (take && byteIdx_q == 6'h02 |-> outData[7:6] == 2'h0)
    else $error("reserved flag bits set");
  a_dup_pulse: assert property (dupHandler |-> reqReady ##1 !dupHandler)
    else $error("dropped handler pulse malformed");
  a_dup_cause: assert property (dupHandler |-> $past(reqValid && reqReady && reqType == edf_pkg::EDF_EL_HANDLER))
    else $error("dropped handler without handler request");
  a_busy_storage: assert property (reqValid && reqReady && reqType == edf_pkg::EDF_EL_STORAGE
      |=> !reqReady [*8] ##[9:400] reqReady)
    else $error("storage request busy span wrong");
  a_count_step: assert property ($changed(storageCount) |-> storageCount == $past(storageCount) + 16'h0001
      || storageCount == 16'h0000)
    else $error("storage count jumped");
endmodule // edf_formatter_properties

bind edf_formatter edf_formatter_properties u_props (.ref_clk, .rst_b, .reqValid, .reqType, .reqReady,
  .dupHandler, .storageCount, .outValid, .outData, .outLast, .outReady);

// *** test/edf_stream_sink.sv ***
module edf_stream_sink (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // descriptor stream
  input wire logic outValid,
  input wire logic [7:0] outData,
  input wire logic outLast,
  output logic outReady = 1'b0,
  // bench control
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] rxQ[$];
  int strideErr = 0;
  int seen = 0;

  // ready registered on the edge, so levels the bench set at the falling edge are settled
  always @(posedge ref_clk) begin
    outReady <= rst_b && !stall;
  end

  // bytes parsed at a fixed 16 or 52 stride, judged at each end marker
  always @(posedge ref_clk) begin
    if (rst_b && outValid && outReady) begin
      rxQ.push_back({outLast, outData});
      seen++;
      if (outLast) begin
        if (seen != 16 && seen != 52) strideErr++;
        seen = 0;
      end
    end
  end
endmodule // edf_stream_sink

// *** test/element_descriptor_formatter_tb.sv ***
module element_descriptor_formatter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] F_FULL = 7'h40, F_MAG = 7'h20, F_FQ = 7'h10, F_LQ = 7'h08;
  localparam logic [6:0] F_LM = 7'h04, F_SEQ = 7'h02, F_SK = 7'h01;
  logic ref_clk = 1'b0, rst_b = 1'b0, reportStart = 1'b0, primary_tag_present = 1'b0;
  logic barcodeFitted = 1'b0, cfgSrcDrive = 1'b0, cfgSrcPort = 1'b0, cfgFrontAccess = 1'b0;
  logic export_permit = 1'b0, import_permit = 1'b0, reqValid = 1'b0, reqFull = 1'b0;
  logic reqMagAbsent = 1'b0, reqFullQuestion = 1'b0, reqLabelQuestion = 1'b0, reqLabelMissing = 1'b0;
  logic reqSeqRange = 1'b0, reqRetracted = 1'b0, operator_placed = 1'b0, reqSrcKnown = 1'b0, stall = 1'b0;
  edf_pkg::edf_emu_e emuMode = edf_pkg::EDF_EMU_A;
  edf_pkg::edf_elem_e reqType = edf_pkg::EDF_EL_HANDLER, reqSrcType = edf_pkg::EDF_EL_STORAGE;
  logic [15:0] reqAddr = 16'h0010, reqSrcAddr = 16'h0000;
  logic [287:0] reqTag = '0;
  logic reqReady, dupHandler, outValid, outLast, outReady;
  logic [15:0] storageCount;
  logic [7:0] outData;
  int errors = 0;
  int compares = 0;

  edf_formatter u_dut (.ref_clk, .rst_b, .reportStart, .primary_tag_present, .emuMode, .barcodeFitted,
    .cfgSrcDrive, .cfgSrcPort, .cfgFrontAccess, .export_permit, .import_permit, .reqValid, .reqType,
    .reqAddr, .reqFull, .reqMagAbsent, .reqFullQuestion, .reqLabelQuestion, .reqLabelMissing, .reqSeqRange,
    .reqRetracted, .operator_placed, .reqSrcKnown, .reqSrcType, .reqSrcAddr, .reqTag, .reqReady,
    .dupHandler, .storageCount, .outValid, .outData, .outLast, .outReady);
  edf_stream_sink u_sink (.ref_clk, .rst_b, .outValid, .outData, .outLast, .outReady, .stall);

  // free-running 25 MHz clock
  initial forever #20 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // expected descriptor byte, worked out from the inputs now applied
  function automatic logic [7:0] exp_byte(input int i);
    logic [7:0] asc;
    logic [7:0] ascq;
    logic [7:0] b2;
    logic sv;
    {asc, ascq} = 16'h0000;
    if (emuMode == edf_pkg::EDF_EMU_A) begin
      if (reqMagAbsent) {asc, ascq} = 16'h9002;
      else if (reqFullQuestion || reqLabelQuestion) {asc, ascq} = 16'h9003;
    end else begin
      if (reqFullQuestion || reqLabelQuestion) {asc, ascq} = 16'h8303;
      else if (reqLabelMissing) {asc, ascq} = 16'h8301;
    end
    sv = reqSrcKnown && (reqSrcType == edf_pkg::EDF_EL_STORAGE || (reqSrcType == edf_pkg::EDF_EL_DRIVE
      && cfgSrcDrive) || (reqSrcType == edf_pkg::EDF_EL_PORT && cfgSrcPort));
    b2 = {5'h00, asc != 8'h00, 1'b0, reqFull};
    if (reqType == edf_pkg::EDF_EL_STORAGE) b2[3] = !reqSeqRange && !reqMagAbsent;
    if (reqType == edf_pkg::EDF_EL_PORT) b2 = b2 | {2'h0, import_permit, export_permit,
      reqRetracted && !cfgFrontAccess, 1'b0, operator_placed, 1'b0};
    case (i)
      0: return reqAddr[15:8];
      1: return reqAddr[7:0];
      2: return b2;
      4: return asc;
      5: return ascq;
      9: return {sv, 7'h00};
      10: return sv ? reqSrcAddr[15:8] : 8'h00;
      11: return sv ? reqSrcAddr[7:0] : 8'h00;
      default: return (primary_tag_present && i >= 12 && i <= 47) ? reqTag[8*(47-i) +: 8] : 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // request and descriptor tasks
  // ----------------------------------------------------------------
  task automatic run_desc(input int hold);
    int n;
    int len;
    logic [8:0] w;
    len = primary_tag_present ? 52 : 16;
    n = 0;
    while (!reqReady) @(negedge ref_clk);
    stall = hold != 0;
    reqValid = 1'b1;
    @(negedge ref_clk);
    reqValid = 1'b0;
    repeat (hold) @(negedge ref_clk);
    if (hold != 0) check("busy while stalled", 8'(reqReady), 8'h00);
    stall = 1'b0;
    while (u_sink.rxQ.size() < len && n < 600) begin
      @(negedge ref_clk);
      n++;
    end
    check("byte count", 8'(u_sink.rxQ.size()), 8'(len));
    for (int i = 0; i < len && u_sink.rxQ.size() > 0; i++) begin
      w = u_sink.rxQ.pop_front();
      check("descriptor byte", w[7:0], exp_byte(i));
      check("end marker", 8'(w[8]), 8'(i == len - 1));
    end
  endtask

  task automatic go(input edf_pkg::edf_elem_e t, input edf_pkg::edf_elem_e st, input logic [6:0] f, input int hold);
    reqType = t;
    reqSrcType = st;
    {reqFull, reqMagAbsent, reqFullQuestion, reqLabelQuestion, reqLabelMissing, reqSeqRange, reqSrcKnown} = f;
    reqAddr = reqAddr + 16'h0103;
    reqSrcAddr = ~reqAddr;
    run_desc(hold);
  endtask

  task automatic start_report();
    reportStart = 1'b1;
    @(negedge ref_clk);
    reportStart = 1'b0;
    @(negedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 36; i++) reqTag[8*i +: 8] = 8'(i * 7 + 3);
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    start_report();
    primary_tag_present = 1'b1;
    go(edf_pkg::EDF_EL_HANDLER, edf_pkg::EDF_EL_STORAGE, F_FULL | F_FQ | F_SK, 0);
    reqValid = 1'b1;
    @(negedge ref_clk);
    reqValid = 1'b0;
    check("dropped handler pulse", 8'(dupHandler), 8'h01);
    check("ready after drop", 8'(reqReady), 8'h01);
    repeat (8) @(negedge ref_clk);
    check("bytes after drop", 8'(u_sink.rxQ.size()), 8'h00);
    primary_tag_present = 1'b0;
    go(edf_pkg::EDF_EL_STORAGE, edf_pkg::EDF_EL_STORAGE, F_MAG, 0);
    go(edf_pkg::EDF_EL_STORAGE, edf_pkg::EDF_EL_STORAGE, F_SEQ | F_FULL | F_SK, 0);
    go(edf_pkg::EDF_EL_STORAGE, edf_pkg::EDF_EL_DRIVE, F_SK, 0);
    cfgSrcDrive = 1'b1;
    go(edf_pkg::EDF_EL_STORAGE, edf_pkg::EDF_EL_DRIVE, F_SK | F_FULL, 0);
    check("storage count", storageCount[7:0], 8'h04);
    emuMode = edf_pkg::EDF_EMU_B;
    go(edf_pkg::EDF_EL_STORAGE, edf_pkg::EDF_EL_PORT, F_LM | F_FULL | F_SK, 0);
    go(edf_pkg::EDF_EL_STORAGE, edf_pkg::EDF_EL_STORAGE, F_FQ, 0);
    barcodeFitted = 1'b1;
    go(edf_pkg::EDF_EL_STORAGE, edf_pkg::EDF_EL_STORAGE, F_LQ | F_FULL, 0);
    emuMode = edf_pkg::EDF_EMU_NATIVE;
    go(edf_pkg::EDF_EL_STORAGE, edf_pkg::EDF_EL_STORAGE, F_FULL, 0);
    cfgSrcPort = 1'b1;
    for (int k = 0; k < 32; k++) begin
      {import_permit, export_permit, cfgFrontAccess, operator_placed, reqRetracted} = 5'(k);
      go(edf_pkg::EDF_EL_PORT, edf_pkg::EDF_EL_PORT, F_SK | 7'(k % 3 == 0) << 6, 0);
    end
    primary_tag_present = 1'b1;
    go(edf_pkg::EDF_EL_PORT, edf_pkg::EDF_EL_STORAGE, F_FULL | F_SK, 40);
    check("idle after drain", 8'(outValid), 8'h00);
    start_report();
    check("count cleared", storageCount[7:0], 8'h00);
    check("stride faults", 8'(u_sink.strideErr), 8'h00);
    conclude();
  end

  // watchdog, far beyond the thousand or so cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    conclude();
  end
endmodule // element_descriptor_formatter_tb
